/* cpu_incdec_move_jump_halt_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_incdec_move_jump_halt_test;
    import incdec_pkg::*;
    typedef struct {op_t op; logic [7:0] imm, work, mem; logic nul;} row_t;
    logic clk = 1'b0, arst_n = 1'b0, valid = 1'b0, wake = 1'b0; // Stimulus
    instr_t instr = '0;
    logic ready, pc_load, wdclr, gate, sleeping; // Observed
    logic [7:0] raddr, rdata, work;
    logic [10:0] pc;
    mem_wr_t wr;
    flags_t flags;
    int failures = 0, compares = 0, n;
    // Memory at 8'h10 walks through wrap at both ends
    row_t rows [11] = '{'{OP_LOAD_WORK_IMMEDIATE, 8'h01, 8'h01, 8'h00, 1'b0},
        '{OP_STORE_WORK_TO_MEMORY, 8'h00, 8'h01, 8'h01, 1'b0},
        '{OP_SUB_ONE_TO_WORK, 8'h00, 8'h00, 8'h01, 1'b1},
        '{OP_LOAD_WORK_IMMEDIATE, 8'hFF, 8'hFF, 8'h01, 1'b1},
        '{OP_SUB_ONE_IN_PLACE, 8'h00, 8'hFF, 8'h00, 1'b1},
        '{OP_SUB_ONE_IN_PLACE, 8'h00, 8'hFF, 8'hFF, 1'b0},
        '{OP_ADD_ONE_TO_WORK, 8'h00, 8'h00, 8'hFF, 1'b1},
        '{OP_LOAD_WORK_FROM_MEMORY, 8'h00, 8'hFF, 8'hFF, 1'b1},
        '{OP_ADD_ONE_IN_PLACE, 8'h00, 8'hFF, 8'h00, 1'b1},
        '{OP_ADD_ONE_IN_PLACE, 8'h00, 8'hFF, 8'h01, 1'b0},
        '{OP_STORE_WORK_TO_MEMORY, 8'h00, 8'hFF, 8'hFF, 1'b0}};
    always #5 clk = ~clk;
    incdec_exec u_incdec_exec (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .INSTR_IN(instr),
        .INSTR_VALID_IN(valid), .MEM_RDATA_IN(rdata), .WAKE_IN(wake),
        .INSTR_READY_OUT(ready), .MEM_RADDR_OUT(raddr), .MEM_WR_OUT(wr), .WORK_OUT(work),
        .FLAGS_OUT(flags), .PC_OUT(pc), .PC_LOAD_OUT(pc_load), .WATCHDOG_CLEAR_OUT(wdclr),
        .CLOCK_GATE_OUT(gate), .SLEEPING_OUT(sleeping));
    data_mem_model u_data_mem_model (.clk_in(clk), .raddr_in(raddr), .wr_in(wr),
        .rdata_out(rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Presents one instruction; valid is left high for the caller
    task automatic issue(input op_t op, input logic [7:0] imm, input logic [10:0] tgt);
        @(posedge clk);
        #1;
        instr = '{op, 8'h10, imm, tgt};
        valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        chk({ready, work, flags}, 12'h800);
        #1;
        arst_n = 1'b1;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].imm, 11'h000);
            valid = 1'b0;
            chk(work, rows[i].work);
            chk(flags.result_null, rows[i].nul);
            chk(ready, 1'b1);
            @(posedge clk);
            #1;
            chk(u_data_mem_model.mem_reg[16], rows[i].mem);
        end
        // Branch, then an instruction held through the dummy cycle
        issue(OP_BRANCH_ABSOLUTE, 8'h00, 11'h5A5);
        instr = '{OP_LOAD_WORK_IMMEDIATE, 8'h10, 8'h3C, 11'h000};
        chk({pc_load, ready, pc}, 13'h15A5);
        @(posedge clk);
        #1;
        chk({pc_load, ready, work}, 10'h1FF);
        issue(OP_SLEEP, 8'h00, 11'h000);
        instr.op = OP_LOAD_WORK_IMMEDIATE;
        chk({gate, sleeping, wdclr, ready, flags, work}, 15'h723C);
        repeat (4) @(posedge clk);
        #1;
        chk({wdclr, ready, work, u_data_mem_model.mem_reg[16]}, 18'h03CFF);
        wake = 1'b1;
        for (n = 0; n < 10 && ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(n < 10, 1'b1);
        @(posedge clk);
        #1;
        wake = 1'b0;
        valid = 1'b0;
        chk({flags, work}, 11'h200);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* data_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Data memory beside the core; read is combinational
module data_mem_model
    import incdec_pkg::*;
(
    input wire logic clk_in,
    input wire logic [MADDR_W-1:0] raddr_in,
    input wire mem_wr_t wr_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem_reg [2**MADDR_W]; // Byte store
    // Cleared at start so expectations are known
    initial begin
        foreach (mem_reg[i]) begin
            mem_reg[i] = 8'h00;
        end
    end
    assign rdata_out = mem_reg[raddr_in];
    // Write lands on the edge that sees the pulse
    always @(posedge clk_in) begin
        if (wr_in.write) begin
            mem_reg[wr_in.addr] <= wr_in.data;
        end
    end
endmodule
`default_nettype wire

/* incdec_exec.sv */
`timescale 1ns/10ps
`default_nettype none

module incdec_exec
    import incdec_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire instr_t INSTR_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [DATA_W-1:0] MEM_RDATA_IN,
    input wire logic WAKE_IN,
    output logic INSTR_READY_OUT,
    output logic [MADDR_W-1:0] MEM_RADDR_OUT,
    output mem_wr_t MEM_WR_OUT,
    output logic [DATA_W-1:0] WORK_OUT,
    output flags_t FLAGS_OUT,
    output logic [PC_W-1:0] PC_OUT,
    output logic PC_LOAD_OUT,
    output logic WATCHDOG_CLEAR_OUT,
    output logic CLOCK_GATE_OUT,
    output logic SLEEPING_OUT
);

    // Elaboration guard: the null test and the wrap assume one byte
    // of data, and the packed carriers are built on these widths
    if (DATA_W != 8) begin : g_bad_data_width
        $error("Data width must be one byte");
    end
    // Memory address must fit the read port and the write carrier
    if (MADDR_W < 1 || MADDR_W > 16) begin : g_bad_addr_width
        $error("Memory address width out of range");
    end
    // Branch target must hold at least one address bit
    if (PC_W < 1 || PC_W > 16) begin : g_bad_pc_width
        $error("Program counter width out of range");
    end

    // Architectural state
    logic [DATA_W-1:0] work_reg; // Working register
    flags_t flags_reg; // Null, sleep and expiry flags
    mem_wr_t mem_wr_reg; // Registered memory write
    logic [PC_W-1:0] pc_reg; // Branch target presented to the core
    logic pc_load_reg; // One-cycle load strobe
    logic wd_clear_reg; // One-cycle watchdog clear
    state_t state_reg; // Current sequencer state
    state_t state_next; // Next sequencer state

    // Wake-up is asynchronous to the core: two-stage synchroniser
    logic wake_meta_reg;
    logic wake_sync_reg;

    logic take; // Instruction accepted this cycle
    logic [DATA_W-1:0] dec_val; // Memory minus one
    logic [DATA_W-1:0] inc_val; // Memory plus one

    // Wrapping step of one byte.
    // The carry is dropped on purpose: both ends wrap modulo one byte,
    // so the null flag is set when a step lands on zero
    // Wrapping step of one byte
    function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] v, input logic up);
        step = up ? v + ONE : v - ONE;
    endfunction

    // Null test shared by the four step ops; the loads do not use it
    function automatic logic is_null(input logic [DATA_W-1:0] v);
        is_null = (v == ZERO);
    endfunction

    // Timing of one accepted instruction:
    //   Edge N: valid and ready high, operand read combinationally
    //   Edge N: work, flags and the write carrier load new values
    //   Cycle N+1: the memory write pulse stands for one cycle
    // Results appear one cycle after acceptance, which keeps the
    // memory read and the memory write of one op in different cycles.
    // Limitation: an op taken on the very next edge reads the byte before
    // the memory takes the previous op's write to it, so it sees the old value.
    // Handshake and operand path
    always_comb begin
        // Only the run state accepts work; dummy and sleep stall fetch.
        // Every other op keeps the state in run, so one cycle each
        INSTR_READY_OUT = (state_reg == ST_RUN);
        take = INSTR_READY_OUT && INSTR_VALID_IN;
        MEM_RADDR_OUT = INSTR_IN.mem_addr;
        dec_val = step(MEM_RDATA_IN, 1'b0);
        inc_val = step(MEM_RDATA_IN, 1'b1);
    end

    // Wake arrives from outside the clock domain.
    // Only the second stage is read by logic; the first may be
    // metastable for part of a cycle and must stay private.
    // Two cycles of latency are traded for a clean level.
    // Wake synchroniser
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= WAKE_IN;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // Sequencer overview:
    //   Run: accepts one instruction per cycle
    //   Dummy: one idle cycle after a branch while the core reloads
    //   Sleep: fetch stalled and clock gate raised until wake
    // The dummy state never looks at the instruction input, so an
    // instruction held over it is taken once, when fetch resumes.
    // Wake is looked at only while asleep; a wake during normal
    // running is ignored, since there is nothing to resume.
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (take && INSTR_IN.op == OP_BRANCH_ABSOLUTE) begin
                    state_next = ST_BRANCH_DUMMY;
                end else if (take && INSTR_IN.op == OP_SLEEP) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_BRANCH_DUMMY: begin
                // Dummy cycle executes nothing, then fetch resumes
                state_next = ST_RUN;
            end
            ST_SLEEP: begin
                if (wake_sync_reg) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Only the two loads and the to-work steps load the register.
    // Sleep, branch and the in-place steps leave it alone, so the
    // core sees the same value across a sleep period.
    // Working register; untouched unless an instruction targets it
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            work_reg <= WORK_RESET;
        end else if (take) begin
            case (INSTR_IN.op)
                OP_SUB_ONE_TO_WORK: begin
                    work_reg <= dec_val;
                end
                OP_ADD_ONE_TO_WORK: begin
                    work_reg <= inc_val;
                end
                OP_LOAD_WORK_FROM_MEMORY: begin
                    work_reg <= MEM_RDATA_IN;
                end
                OP_LOAD_WORK_IMMEDIATE: begin
                    work_reg <= INSTR_IN.immediate;
                end
                default: begin
                    // Sleep and branch leave it intact
                    work_reg <= work_reg;
                end
            endcase
        end
    end

    // The address follows the decode stage every cycle; only the
    // write bit qualifies it, which saves a load enable on the address.
    // Data holds its last value when no write is made, so the
    // carrier does not toggle needlessly between writes.
    // Hazard: a consumer must never use addr or data without write.
    // Memory write port, one cycle per instruction
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            mem_wr_reg <= '0;
        end else begin
            // Default: no write, so sleep never disturbs memory
            mem_wr_reg.write <= 1'b0;
            mem_wr_reg.addr <= INSTR_IN.mem_addr;
            mem_wr_reg.data <= mem_wr_reg.data;
            if (take) begin
                case (INSTR_IN.op)
                    OP_SUB_ONE_IN_PLACE: begin
                        mem_wr_reg.write <= 1'b1;
                        mem_wr_reg.data <= dec_val;
                    end
                    OP_ADD_ONE_IN_PLACE: begin
                        mem_wr_reg.write <= 1'b1;
                        mem_wr_reg.data <= inc_val;
                    end
                    OP_STORE_WORK_TO_MEMORY: begin
                        mem_wr_reg.write <= 1'b1;
                        mem_wr_reg.data <= work_reg;
                    end
                    default: begin
                        mem_wr_reg.write <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Each op writes only the flags it owns: the steps touch the
    // null flag, sleep touches the sleep and expiry flags.
    // Nothing in this block clears the sleep flag; the watchdog and
    // wake logic outside own that, so it stays set after wake.
    // Moves and branch never disturb any flag.
    // Status flags
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            flags_reg <= FLAGS_RESET;
        end else if (take) begin
            case (INSTR_IN.op)
                OP_SUB_ONE_IN_PLACE, OP_SUB_ONE_TO_WORK: begin
                    flags_reg.result_null <= is_null(dec_val);
                end
                OP_ADD_ONE_IN_PLACE, OP_ADD_ONE_TO_WORK: begin
                    flags_reg.result_null <= is_null(inc_val);
                end
                OP_SLEEP: begin
                    flags_reg.sleep_entered_flag <= 1'b1;
                    flags_reg.watchdog_expiry_flag <= 1'b0;
                end
                default: begin
                    // Moves and branch leave every flag alone
                    flags_reg <= flags_reg;
                end
            endcase
        end
    end

    // Both strobes are single-cycle pulses from flip-flops, so the
    // program counter and the watchdog see glitch-free requests.
    // The target is held after the pulse for observation only;
    // the core must act on it during the pulse.
    // Branch target and watchdog clear strobes
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pc_reg <= PC_RESET;
            pc_load_reg <= 1'b0;
            wd_clear_reg <= 1'b0;
        end else begin
            pc_load_reg <= take && (INSTR_IN.op == OP_BRANCH_ABSOLUTE);
            wd_clear_reg <= take && (INSTR_IN.op == OP_SLEEP);
            if (take && INSTR_IN.op == OP_BRANCH_ABSOLUTE) begin
                pc_reg <= INSTR_IN.target;
            end
        end
    end

    // All data outputs come straight from flip-flops.
    // The gate level is decoded from the state register alone, so it
    // cannot glitch on input changes while the clock is running.
    // Sleeping mirrors the gate for logic that must not use a clock
    // enable derived from the gating cell.
    // Outputs; clock gate is a level so the core's gating cell can use it
    always_comb begin
        MEM_WR_OUT = mem_wr_reg;
        WORK_OUT = work_reg;
        FLAGS_OUT = flags_reg;
        PC_OUT = pc_reg;
        PC_LOAD_OUT = pc_load_reg;
        WATCHDOG_CLEAR_OUT = wd_clear_reg;
        CLOCK_GATE_OUT = (state_reg == ST_SLEEP);
        SLEEPING_OUT = (state_reg == ST_SLEEP);
    end

endmodule

`default_nettype wire

/* incdec_exec_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the executor
module incdec_exec_checker
    import incdec_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire instr_t INSTR_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [DATA_W-1:0] MEM_RDATA_IN,
    input wire logic INSTR_READY_OUT,
    input wire mem_wr_t MEM_WR_OUT,
    input wire logic [DATA_W-1:0] WORK_OUT,
    input wire flags_t FLAGS_OUT,
    input wire logic [PC_W-1:0] PC_OUT,
    input wire logic PC_LOAD_OUT,
    input wire logic WATCHDOG_CLEAR_OUT,
    input wire logic CLOCK_GATE_OUT,
    input wire logic SLEEPING_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    wire logic take = INSTR_VALID_IN && INSTR_READY_OUT; // Accepted here
    property p_dec_mem;
        take && INSTR_IN.op == OP_SUB_ONE_IN_PLACE |=> MEM_WR_OUT.write &&
            MEM_WR_OUT.data == $past(MEM_RDATA_IN) - ONE &&
            FLAGS_OUT.result_null == (MEM_WR_OUT.data == ZERO);
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("dec mem");
    property p_dec_work;
        take && INSTR_IN.op == OP_SUB_ONE_TO_WORK |=>
            WORK_OUT == $past(MEM_RDATA_IN) - ONE && !MEM_WR_OUT.write;
    endproperty
    a_dec_work: assert property (p_dec_work) else $error("dec work");
    property p_inc_mem;
        take && INSTR_IN.op == OP_ADD_ONE_IN_PLACE |=> MEM_WR_OUT.write &&
            MEM_WR_OUT.data == $past(MEM_RDATA_IN) + ONE;
    endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("inc mem");
    property p_inc_work;
        take && INSTR_IN.op == OP_ADD_ONE_TO_WORK |=>
            WORK_OUT == $past(MEM_RDATA_IN) + ONE && !MEM_WR_OUT.write;
    endproperty
    a_inc_work: assert property (p_inc_work) else $error("inc work");
    property p_sleep;
        take && INSTR_IN.op == OP_SLEEP |=> CLOCK_GATE_OUT && SLEEPING_OUT &&
            WATCHDOG_CLEAR_OUT && !INSTR_READY_OUT &&
            FLAGS_OUT.sleep_entered_flag && !FLAGS_OUT.watchdog_expiry_flag;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry");
    property p_sleep_keep;
        SLEEPING_OUT |=> !MEM_WR_OUT.write && $stable(WORK_OUT);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("sleep keep");
    property p_branch;
        take && INSTR_IN.op == OP_BRANCH_ABSOLUTE |=> PC_LOAD_OUT &&
            PC_OUT == $past(INSTR_IN.target) && !INSTR_READY_OUT &&
            $stable(FLAGS_OUT) ##1 INSTR_READY_OUT && !PC_LOAD_OUT;
    endproperty
    a_branch: assert property (p_branch) else $error("branch");
    property p_load_mem;
        take && INSTR_IN.op == OP_LOAD_WORK_FROM_MEMORY |=>
            WORK_OUT == $past(MEM_RDATA_IN) && $stable(FLAGS_OUT);
    endproperty
    a_load_mem: assert property (p_load_mem) else $error("load mem");
    property p_load_imm;
        take && INSTR_IN.op == OP_LOAD_WORK_IMMEDIATE |=>
            WORK_OUT == $past(INSTR_IN.immediate) && $stable(FLAGS_OUT);
    endproperty
    a_load_imm: assert property (p_load_imm) else $error("load imm");
    property p_store;
        take && INSTR_IN.op == OP_STORE_WORK_TO_MEMORY |=> MEM_WR_OUT.write &&
            MEM_WR_OUT.data == $past(WORK_OUT) && $stable(FLAGS_OUT) &&
            MEM_WR_OUT.addr == $past(INSTR_IN.mem_addr);
    endproperty
    a_store: assert property (p_store) else $error("store");
endmodule
bind incdec_exec incdec_exec_checker u_incdec_exec_checker (.SYS_CLK_IN, .ARST_N_IN,
    .INSTR_IN, .INSTR_VALID_IN, .MEM_RDATA_IN, .INSTR_READY_OUT, .MEM_WR_OUT, .WORK_OUT,
    .FLAGS_OUT, .PC_OUT, .PC_LOAD_OUT, .WATCHDOG_CLEAR_OUT, .CLOCK_GATE_OUT, .SLEEPING_OUT);
`default_nettype wire

/* incdec_pkg.sv */
package incdec_pkg;

    // Core data and address widths
    localparam int DATA_W = 8;
    localparam int MADDR_W = 8;
    localparam int PC_W = 11;

    // Operation codes presented by the decode stage
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SUB_ONE_IN_PLACE = 4'h1,
        OP_SUB_ONE_TO_WORK = 4'h2,
        OP_ADD_ONE_IN_PLACE = 4'h3,
        OP_ADD_ONE_TO_WORK = 4'h4,
        OP_SLEEP = 4'h5,
        OP_BRANCH_ABSOLUTE = 4'h6,
        OP_LOAD_WORK_FROM_MEMORY = 4'h7,
        OP_LOAD_WORK_IMMEDIATE = 4'h8,
        OP_STORE_WORK_TO_MEMORY = 4'h9
    } op_t;

    // One decoded instruction from the fetch/decode path
    typedef struct packed {
        op_t op;
        logic [MADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] immediate;
        logic [PC_W-1:0] target;
    } instr_t;

    // Write request towards data memory
    typedef struct packed {
        logic write;
        logic [MADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

    // Status flags kept by this block
    typedef struct packed {
        logic result_null;
        logic sleep_entered_flag;
        logic watchdog_expiry_flag;
    } flags_t;

    // Work and PC reset values, the step and null-test constants, then the flag reset value
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [DATA_W-1:0] ONE = 8'h01;
    localparam logic [DATA_W-1:0] ZERO = 8'h00;
    localparam flags_t FLAGS_RESET = 3'h0;

    // Execution sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_BRANCH_DUMMY = 2'b01,
        ST_SLEEP = 2'b10
    } state_t;

endpackage
